// *** design/scr_ctrl.sv ***
// Serial control register block: APB registers and decoded serial behaviour
//
// Notes on behaviour
// - Framed enable turns select pin into sync.
// - Sync direction set means input, clear output.
// - Frame polarity sets select/sync active level.
// - Auto select drives pin during master transfers.
// - Pulse width and lead/coincident edge selection.
// - Pulse count code gives characters per pulse.
// - Baud source picks reference or bus clock.
// - Source and buffer bits locked while on.
// - Deep buffer bit enables multi-entry buffering.
// - Module-on bit enables the peripheral.
// - Idle stop halts block during processor idle.
// - Pin disables release data pins to port.
// - Audio size codes select data/channel/frame sizes.
// - Normal size codes give 32/16/8 bit words.
// - Master sample phase end or middle; slave middle.
// - Edge bit picks output change transition, except when framed.
// - Clock polarity; audio forces idle high.
// - Slave honours active-low select when enabled.
// - Master bit selects master or slave role.
// - Transmit request threshold by mode field.
// - Receive request threshold by mode field.
// - Audio enable selects codec protocol operation.
`timescale 1ns/100ps
module scr_ctrl #(
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	// System state
	input  wire logic                 cpu_idle,
	// Serial engine interface
	input  wire scr_pkg::scr_engine_s eng,
	input  wire logic [$clog2(DEPTH+1)-1:0] tx_count,
	input  wire logic [$clog2(DEPTH+1)-1:0] rx_count,
	output scr_pkg::scr_ctrl_s        ctrl,
	output logic                      run_enable,
	output logic                      audio_mode,
	output logic [5:0]                data_bits,
	output logic [6:0]                channel_bits,
	output logic [6:0]                frame_bits,
	output logic                      sclk_idle_level,
	output logic                      shift_on_idle_edge,
	output logic                      sample_at_end,
	output logic                      slave_selected,
	output logic                      frame_sync_seen,
	output logic                      tx_req,
	output logic                      rx_req,
	// Pin ownership
	output logic                      serial_out_owned,
	output logic                      serial_in_owned,
	// Select pin
	input  wire logic                 select_pin_in,
	output logic                      select_pin_out,
	output logic                      select_pin_oe
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic        audio_reg;
	logic [31:0] rdata_reg;
	logic        sel_meta_reg;
	logic        sel_sync_reg;
	logic        sel_last_reg;
	logic        frame_sync_signal_pulse;
	logic        frame_sync_signal_gen_en;
	logic        wr_access;
	logic        rd_setup;
	logic        addr_ok;
	logic [31:0] stat_word;
	logic        sel_active_in;

	// The threshold decode needs a half level distinct from empty
	if (DEPTH < 2) begin : g_depth_check
		$error("DEPTH must be at least 2");
	end

	assign wr_access = psel && penable && pwrite;
	assign rd_setup  = psel && !penable && !pwrite;
	assign addr_ok   = (paddr == scr_pkg::ADDR_CTRL) || (paddr == scr_pkg::ADDR_CTRL2) ||
		(paddr == scr_pkg::ADDR_STAT);

	// Zero wait states; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_ok;

	// Locked bits keep their value while the module is on
	always_comb begin
		ctrl_next = ctrl_reg;
		if (ctrl_reg[scr_pkg::POS_MODULE_ON]) begin
			ctrl_next = (pwdata & scr_pkg::CTRL_MASK & ~scr_pkg::LOCK_MASK) |
				(ctrl_reg & scr_pkg::LOCK_MASK);
		end else begin
			ctrl_next = pwdata & scr_pkg::CTRL_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= scr_pkg::CTRL_RESET;
		end else if (wr_access && paddr == scr_pkg::ADDR_CTRL) begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Audio enable shares the lock of the module-on bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			audio_reg <= 1'b0;
		end else if (wr_access && paddr == scr_pkg::ADDR_CTRL2 &&
				!ctrl_reg[scr_pkg::POS_MODULE_ON]) begin
			audio_reg <= pwdata[scr_pkg::POS_AUDIO_EN];
		end
	end

	assign stat_word = {24'h00_0000, frame_sync_seen, slave_selected, eng.shift_empty,
		eng.xfer_active, rx_req, tx_req, ctrl_reg[scr_pkg::POS_MODULE_ON], run_enable};

	// Read data captured in the setup phase so it comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h0000_0000;
		end else if (rd_setup) begin
			case (paddr)
				scr_pkg::ADDR_CTRL:  rdata_reg <= ctrl_reg;
				scr_pkg::ADDR_CTRL2: rdata_reg <= {24'h00_0000, audio_reg, 7'h00};
				scr_pkg::ADDR_STAT:  rdata_reg <= stat_word;
				default:             rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	assign prdata = rdata_reg;

	// ------------------------------------------------------------
	// Decoded configuration
	// ------------------------------------------------------------
	// Baud source and deep buffer travel to the engine inside this word
	assign ctrl = scr_pkg::scr_ctrl_s'({ctrl_reg[31:23], ctrl_reg[17:15],
		ctrl_reg[13:0]});
	assign audio_mode = audio_reg;

	// Idle stop freezes activity while the processor idles
	assign run_enable = ctrl.module_on && !(ctrl.idle_stop && cpu_idle);

	always_comb begin
		data_bits    = scr_pkg::BITS_8;
		channel_bits = 7'(scr_pkg::BITS_16);
		frame_bits   = scr_pkg::BITS_32;
		if (audio_reg) begin
			case ({ctrl.word_size_high, ctrl.word_size_low})
				2'b11: begin
					data_bits    = scr_pkg::BITS_24;
					channel_bits = scr_pkg::BITS_32;
					frame_bits   = scr_pkg::BITS_64;
				end
				2'b10: begin
					data_bits    = 6'(scr_pkg::BITS_32);
					channel_bits = scr_pkg::BITS_32;
					frame_bits   = scr_pkg::BITS_64;
				end
				2'b01: begin
					data_bits    = scr_pkg::BITS_16;
					channel_bits = scr_pkg::BITS_32;
					frame_bits   = scr_pkg::BITS_64;
				end
				default: begin
					data_bits    = scr_pkg::BITS_16;
					channel_bits = 7'(scr_pkg::BITS_16);
					frame_bits   = scr_pkg::BITS_32;
				end
			endcase
		end else begin
			if (ctrl.word_size_high) begin
				data_bits = 6'(scr_pkg::BITS_32);
			end else if (ctrl.word_size_low) begin
				data_bits = scr_pkg::BITS_16;
			end else begin
				data_bits = scr_pkg::BITS_8;
			end
			channel_bits = 7'(data_bits);
			frame_bits   = 7'(data_bits);
		end
	end

	// Audio forces idle-high clock regardless of the stored bit
	assign sclk_idle_level    = audio_reg | ctrl.clock_idle_polarity;
	// Edge choice is meaningless when framed, so it is masked there
	assign shift_on_idle_edge = ctrl.clock_edge && !ctrl.framed_mode_enable;
	assign sample_at_end      = ctrl.master_select && ctrl.input_sample_phase;

	assign serial_out_owned = ctrl.module_on && !ctrl.serial_out_disable;
	assign serial_in_owned  = ctrl.module_on && !ctrl.serial_in_disable;

	// ------------------------------------------------------------
	// Select pin
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Idle level of the active-low pin, so no false edge follows reset
			sel_meta_reg <= 1'b1;
			sel_sync_reg <= 1'b1;
		end else begin
			sel_meta_reg <= select_pin_in;
			sel_sync_reg <= sel_meta_reg;
		end
	end

	assign frame_sync_signal_gen_en = run_enable && ctrl.framed_mode_enable && !ctrl.frame_sync_direction;

	scr_frame_gen u_frame_gen (
		.pclk        (pclk),
		.presetn     (presetn),
		.enable      (frame_sync_signal_gen_en),
		.pulse_width (ctrl.frame_pulse_width),
		.edge_select (ctrl.frame_edge_select),
		.pulse_count (ctrl.frame_pulse_count),
		.eng         (eng),
		.pulse       (frame_sync_signal_pulse)
	);

	// Pin level through the polarity bit, active high internally
	assign sel_active_in = ctrl.frame_polarity ? sel_sync_reg : !sel_sync_reg;

	always_comb begin
		select_pin_oe  = 1'b0;
		select_pin_out = !ctrl.frame_polarity;
		if (ctrl.module_on && ctrl.framed_mode_enable) begin
			if (!ctrl.frame_sync_direction) begin
				select_pin_oe  = 1'b1;
				select_pin_out = frame_sync_signal_pulse ~^ ctrl.frame_polarity;
			end
		end else if (ctrl.module_on && ctrl.master_select && ctrl.master_auto_select) begin
			select_pin_oe  = 1'b1;
			select_pin_out = eng.xfer_active ~^ ctrl.frame_polarity;
		end
	end

	// Slave select is active low; unused pin means always selected
	assign slave_selected = !ctrl.master_select &&
		(!ctrl.slave_select_use || !sel_sync_reg);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_last_reg <= 1'b0;
		end else begin
			sel_last_reg <= sel_active_in;
		end
	end

	assign frame_sync_seen = ctrl.module_on && ctrl.framed_mode_enable &&
		ctrl.frame_sync_direction && sel_active_in && !sel_last_reg;

	// ------------------------------------------------------------
	// Interrupt requests
	// ------------------------------------------------------------
	scr_irq_level #(
		.DEPTH (DEPTH)
	) u_irq_level (
		.tx_mode     (ctrl.tx_irq_mode),
		.rx_mode     (ctrl.rx_irq_mode),
		.tx_count    (tx_count),
		.rx_count    (rx_count),
		.shift_empty (eng.shift_empty),
		.tx_req      (tx_req),
		.rx_req      (rx_req)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_locked_hold: assert property (
		(wr_access && paddr == scr_pkg::ADDR_CTRL && ctrl_reg[scr_pkg::POS_MODULE_ON])
		|=> (ctrl_reg[23] == $past(ctrl_reg[23]) && ctrl_reg[16] == $past(ctrl_reg[16])))
		else $error("locked field changed while on");
	a_unlocked_rest: assert property (
		(wr_access && paddr == scr_pkg::ADDR_CTRL)
		|=> ctrl_reg[15:0] == ($past(pwdata[15:0]) & scr_pkg::CTRL_MASK[15:0]))
		else $error("unlocked bits not written");
	a_audio_clock: assert property (
		audio_reg |-> sclk_idle_level)
		else $error("audio mode clock not idle high");
	a_slave_sample: assert property (
		!ctrl.master_select |-> !sample_at_end)
		else $error("slave sampled at end");
	a_word_len: assert property (
		(!audio_reg && !ctrl.word_size_high && !ctrl.word_size_low) |-> data_bits == 6'h08)
		else $error("8-bit word length wrong");
	a_pin_release: assert property (
		ctrl.serial_out_disable |-> !serial_out_owned)
		else $error("serial out pin not released");
	a_auto_select: assert property (
		(ctrl.module_on && !ctrl.framed_mode_enable && ctrl.master_select &&
		ctrl.master_auto_select && eng.xfer_active)
		|-> (select_pin_oe && select_pin_out == ctrl.frame_polarity))
		else $error("auto select not driven active");
	a_idle_stop: assert property (
		(ctrl.idle_stop && cpu_idle) |-> !run_enable)
		else $error("module runs in idle with idle stop");
	a_frame_sync_signal_width: assert property (
		(frame_sync_signal_gen_en && !ctrl.frame_pulse_width && frame_sync_signal_pulse && eng.bit_tick &&
		!u_frame_gen.fire) |=> !frame_sync_signal_pulse)
		else $error("one-clock sync pulse too long");
	a_sync_input: assert property (
		(ctrl.framed_mode_enable && ctrl.frame_sync_direction) |-> !select_pin_oe)
		else $error("sync input pin driven");
	a_tx_empty: assert property (
		(ctrl.tx_irq_mode == 2'b01) |-> (tx_req == (tx_count == '0)))
		else $error("transmit empty request wrong");
	a_audio_size: assert property (
		(audio_reg && ctrl.word_size_high && ctrl.word_size_low) |->
		(data_bits == scr_pkg::BITS_24 && channel_bits == scr_pkg::BITS_32 &&
		frame_bits == scr_pkg::BITS_64))
		else $error("audio 24-bit sizes wrong");
	a_rx_full: assert property (
		(ctrl.rx_irq_mode == 2'b11) |-> (rx_req == (rx_count == DEPTH)))
		else $error("receive full request wrong");
	a_sel_honour: assert property (
		(!ctrl.master_select && ctrl.slave_select_use && sel_sync_reg) |-> !slave_selected)
		else $error("deselected slave reported selected");
	a_module_off: assert property (
		!ctrl.module_on |-> (!run_enable && !serial_out_owned && !serial_in_owned))
		else $error("module active while off");

	c_framed_master: cover property (frame_sync_signal_gen_en && frame_sync_signal_pulse);
	c_locked_write: cover property (wr_access && ctrl_reg[scr_pkg::POS_MODULE_ON]);
	c_audio_24: cover property (audio_reg && data_bits == scr_pkg::BITS_24);
	c_sync_seen: cover property (frame_sync_seen);

endmodule

// *** design/scr_pkg.sv ***
// Shared constants and types for the serial control register block
package scr_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, 32-bit words)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_CTRL2 = 8'h04;
	localparam logic [7:0] ADDR_STAT  = 8'h08;

	// ------------------------------------------------------------
	// Main and second control word field positions
	// ------------------------------------------------------------
	localparam int POS_FRAMED_EN   = 31;
	localparam int POS_FRAME_SYNC_SIGNAL_DIR   = 30;
	localparam int POS_FRAME_POL   = 29;
	localparam int POS_AUTO_SEL    = 28;
	localparam int POS_PULSE_WIDTH = 27;
	localparam int POS_PULSE_CNT   = 24;
	localparam int POS_BAUD_SRC    = 23;
	localparam int POS_EDGE_SEL    = 17;
	localparam int POS_DEEP_BUF    = 16;
	localparam int POS_MODULE_ON   = 15;
	localparam int POS_IDLE_STOP   = 13;
	localparam int POS_OUT_DIS     = 12;
	localparam int POS_SIZE_HIGH   = 11;
	localparam int POS_SIZE_LOW    = 10;
	localparam int POS_SAMPLE_PH   = 9;
	localparam int POS_CLK_EDGE    = 8;
	localparam int POS_SEL_USE     = 7;
	localparam int POS_CLK_POL     = 6;
	localparam int POS_MASTER      = 5;
	localparam int POS_IN_DIS      = 4;
	localparam int POS_TX_MODE     = 2;
	localparam int POS_RX_MODE     = 0;
	localparam int POS_AUDIO_EN    = 7;

	// Writable bits; all others read as zero
	localparam logic [31:0] CTRL_MASK  = 32'hff83_bfff;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] LOCK_MASK  = 32'h0081_0000;
	localparam logic [31:0] CTRL2_MASK = 32'h0000_0080;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [2:0] PULSE_CNT_MAX = 3'h5;
	localparam logic [5:0] BITS_8  = 6'h08;
	localparam logic [5:0] BITS_16 = 6'h10;
	localparam logic [5:0] BITS_24 = 6'h18;
	localparam logic [6:0] BITS_32 = 7'h20;
	localparam logic [6:0] BITS_64 = 7'h40;

	typedef enum logic [1:0] {
		IRQ_DONE,
		IRQ_EMPTY_OR_ANY,
		IRQ_HALF,
		IRQ_EDGE
	} scr_irq_mode_e;

	// Decoded control word as seen by the serial engine
	typedef struct packed {
		logic       framed_mode_enable;
		logic       frame_sync_direction;
		logic       frame_polarity;
		logic       master_auto_select;
		logic       frame_pulse_width;
		logic [2:0] frame_pulse_count;
		logic       baud_clock_source;
		logic       frame_edge_select;
		logic       deep_buffer_enable;
		logic       module_on;
		logic       idle_stop;
		logic       serial_out_disable;
		logic       word_size_high;
		logic       word_size_low;
		logic       input_sample_phase;
		logic       clock_edge;
		logic       slave_select_use;
		logic       clock_idle_polarity;
		logic       master_select;
		logic       serial_in_disable;
		logic [1:0] tx_irq_mode;
		logic [1:0] rx_irq_mode;
	} scr_ctrl_s;

	// Serial engine timing strobes, all on pclk
	typedef struct packed {
		logic bit_tick;
		logic char_lead;
		logic char_start;
		logic char_end;
		logic xfer_active;
		logic shift_empty;
	} scr_engine_s;

endpackage

// *** design/scr_frame_gen.sv ***
// Frame sync pulse generator: character counting and pulse shaping
`timescale 1ns/100ps
module scr_frame_gen (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// Control
	input  wire logic               enable,
	input  wire logic               pulse_width,
	input  wire logic               edge_select,
	input  wire logic [2:0]         pulse_count,
	// Engine strobes
	input  wire scr_pkg::scr_engine_s eng,
	// Pulse out, active high
	output logic                    pulse
);

	logic [4:0] char_cnt_reg;
	logic [4:0] char_lim;
	logic       fire;

	// Reserved counts fall back to one character per pulse
	assign char_lim = (pulse_count > scr_pkg::PULSE_CNT_MAX) ? 5'h00 :
		5'((6'h01 << pulse_count) - 6'h01);
	assign fire = (char_cnt_reg == 5'h00) &&
		(edge_select ? eng.char_start : eng.char_lead);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			char_cnt_reg <= 5'h00;
		end else if (!enable) begin
			char_cnt_reg <= 5'h00;
		end else if (eng.char_end) begin
			char_cnt_reg <= (char_cnt_reg >= char_lim) ? 5'h00 : char_cnt_reg + 5'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse <= 1'b0;
		end else if (!enable) begin
			pulse <= 1'b0;
		end else if (fire) begin
			pulse <= 1'b1;
		end else if (pulse_width ? eng.char_end : eng.bit_tick) begin
			pulse <= 1'b0;
		end
	end

endmodule

// *** design/scr_irq_level.sv ***
// Buffer threshold decode for transmit and receive interrupt requests
`timescale 1ns/100ps
module scr_irq_level #(
	parameter int DEPTH = 8
) (
	// Modes
	input  wire logic [1:0]           tx_mode,
	input  wire logic [1:0]           rx_mode,
	// Buffer state
	input  wire logic [$clog2(DEPTH+1)-1:0] tx_count,
	input  wire logic [$clog2(DEPTH+1)-1:0] rx_count,
	input  wire logic                 shift_empty,
	// Requests
	output logic                      tx_req,
	output logic                      rx_req
);

	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);

	if (DEPTH < 2) begin : g_depth_check
		$error("DEPTH must be at least 2");
	end

	always_comb begin
		case (scr_pkg::scr_irq_mode_e'(tx_mode))
			scr_pkg::IRQ_EDGE:         tx_req = tx_count < FULL;
			scr_pkg::IRQ_HALF:         tx_req = tx_count <= HALF;
			scr_pkg::IRQ_EMPTY_OR_ANY: tx_req = tx_count == '0;
			default:                   tx_req = (tx_count == '0) && shift_empty;
		endcase
		case (scr_pkg::scr_irq_mode_e'(rx_mode))
			scr_pkg::IRQ_EDGE:         rx_req = rx_count == FULL;
			scr_pkg::IRQ_HALF:         rx_req = rx_count >= HALF;
			scr_pkg::IRQ_EMPTY_OR_ANY: rx_req = rx_count != '0;
			default:                   rx_req = rx_count == '0;
		endcase
	end

endmodule

// *** tb/scr_far_model.sv ***
// Far-end serial model: character strobes and select pin level
`timescale 1ns/100ps
module scr_far_model (
	// Clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// Bench control
	input  wire logic            go,
	input  wire logic            pol,
	// Toward the block
	output scr_pkg::scr_engine_s eng,
	output logic                 sync_pin
);
	logic [3:0] step_reg;

	// ------------------------------------------------------------
	// Character sequencer
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_reg <= 4'h0;
		end else if (step_reg == 4'h0) begin
			step_reg <= {3'h0, go};
		end else begin
			step_reg <= (step_reg == 4'ha) ? 4'h0 : step_reg + 4'h1;
		end
	end

	// Eight-bit character: lead, eight ticks, end on the last tick
	assign eng = {step_reg >= 4'h2 && step_reg <= 4'h9, step_reg == 4'h1,
		step_reg == 4'h2, step_reg == 4'h9, step_reg != 4'h0, step_reg == 4'h0};
	// Sync pulse one bit time ahead of the character, inactive otherwise
	assign sync_pin = (step_reg == 4'h1) ? pol : ~pol;
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the serial control register block
`timescale 1ns/100ps
module tb;
	localparam logic [31:0] ON = 32'h8000, MST = 32'h20, FR = 32'h8000_0000;
	localparam logic [31:0] DIR = 32'h4000_0000, POL = 32'h2000_0000, PW = 32'h0800_0000;
	localparam logic [31:0] AUTO = 32'h1000_0000, EDG = 32'h2_0000, IDLE_STOP = 32'h2000;
	logic        pclk, presetn, psel, penable, pwrite, cpu_idle, go, pol, sync_pin, last_err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, run_enable, audio_mode, sclk_idle_level;
	logic        shift_on_idle_edge, sample_at_end, slave_selected, frame_sync_seen;
	logic        tx_req, rx_req, serial_out_owned, serial_in_owned, select_pin_out, select_pin_oe;
	logic [3:0]  tx_count, rx_count;
	logic [5:0]  data_bits;
	logic [6:0]  channel_bits, frame_bits;
	scr_pkg::scr_ctrl_s   ctrl;
	scr_pkg::scr_engine_s eng;
	int          err_count, checks_done;
	int          dtab[8] = '{8, 16, 32, 32, 16, 16, 32, 24};
	int          ctab[8] = '{8, 16, 32, 32, 16, 32, 32, 32};
	int          ftab[8] = '{8, 16, 32, 32, 32, 64, 64, 64};
	int          itab[8][5] = '{'{3, 7, 8, 1, 1}, '{3, 8, 7, 0, 0}, '{2, 4, 4, 1, 1},
		'{2, 5, 3, 0, 0}, '{1, 0, 1, 1, 1}, '{1, 1, 0, 0, 0}, '{0, 0, 0, 1, 1}, '{0, 1, 1, 0, 0}};

	scr_ctrl #(.DEPTH(8)) scr_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cpu_idle, .eng, .tx_count, .rx_count, .ctrl,
		.run_enable, .audio_mode, .data_bits, .channel_bits, .frame_bits, .sclk_idle_level,
		.shift_on_idle_edge, .sample_at_end, .slave_selected, .frame_sync_seen, .tx_req,
		.rx_req, .serial_out_owned, .serial_in_owned, .select_pin_in(sync_pin),
		.select_pin_out, .select_pin_oe);
	scr_far_model scr_far_model_inst (.pclk, .presetn, .go, .pol, .eng, .sync_pin);

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] d);
		apb(1'b1, scr_pkg::ADDR_CTRL, d);
		@(negedge pclk);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, "read");
	endtask

	// Counts clocks with the select pin driven active, or frame pulses seen on the sync input
	task automatic frm(input logic [31:0] w, input int nch, input int exp);
		int c;
		c = 0;
		pol <= w[29];
		wr(w);
		repeat (nch) begin
			@(posedge pclk);
			go <= 1'b1;
			@(posedge pclk);
			go <= 1'b0;
			repeat (12) begin
				@(negedge pclk);
				c += w[30] ? frame_sync_seen : (select_pin_oe && select_pin_out == w[29]);
			end
		end
		chk(c, exp, "frame pulses");
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rchk(scr_pkg::ADDR_CTRL, 32'h0);
		chk(data_bits, 8, "reset size");
		wr(32'hffff_7fff);
		rchk(scr_pkg::ADDR_CTRL, 32'hff83_3fff);
		chk(32'(ctrl), 32'h03ff_bfff, "fields");
		wr(ON | 32'h0081_0000);
		rchk(scr_pkg::ADDR_CTRL, 32'h0081_8000);
		chk({ctrl.baud_clock_source, ctrl.deep_buffer_enable}, 2'b11, "src buf");
		wr(32'h0);
		repeat (2) @(posedge pclk);
		rchk(scr_pkg::ADDR_CTRL, 32'h0081_0000);
		wr(32'h0);
		rchk(scr_pkg::ADDR_CTRL, 32'h0);
		wr(ON);
		wr(ON | 32'h0081_1000);
		rchk(scr_pkg::ADDR_CTRL, 32'h0000_9000);
		wr(32'h0);
		apb(1'b1, 8'h0c, 32'h1);
		chk(last_err, 1, "unmapped err");
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 0, "unmapped data");
	endtask

	task automatic t_sizes;
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, scr_pkg::ADDR_CTRL2, i[2] ? 32'h80 : 32'h0);
			wr(32'(i[1:0]) << 10);
			chk(data_bits, dtab[i], "data bits");
			chk(channel_bits, ctab[i], "chan bits");
			chk(frame_bits, ftab[i], "frame bits");
			chk(sclk_idle_level, i[2], "idle level");
			chk(audio_mode, i[2], "audio");
			rchk(scr_pkg::ADDR_CTRL2, i[2] ? 32'h80 : 32'h0);
		end
		apb(1'b1, scr_pkg::ADDR_CTRL2, 32'h0);
	endtask

	task automatic t_modes;
		wr(ON | IDLE_STOP);
		chk(run_enable, 1, "run");
		@(posedge pclk);
		cpu_idle <= 1'b1;
		@(negedge pclk);
		chk(run_enable, 0, "idle stop");
		wr(ON);
		chk(run_enable, 1, "idle run");
		rchk(scr_pkg::ADDR_STAT, 32'h6f);
		wr(ON | 32'h1000);
		chk({serial_out_owned, serial_in_owned}, 2'b01, "out dis");
		wr(ON | 32'h10);
		chk({serial_out_owned, serial_in_owned}, 2'b10, "in dis");
		wr(MST | 32'h340);
		chk({sample_at_end, shift_on_idle_edge, sclk_idle_level}, 3'b111, "m");
		wr(FR | 32'h300);
		chk({sample_at_end, shift_on_idle_edge, sclk_idle_level}, 3'b000, "s");
		for (int i = 0; i < 8; i++) begin
			wr(32'(itab[i][0] * 5));
			@(posedge pclk);
			tx_count <= 4'(itab[i][1]);
			rx_count <= 4'(itab[i][2]);
			@(negedge pclk);
			chk(tx_req, itab[i][3], "tx req");
			chk(rx_req, itab[i][4], "rx req");
		end
	endtask

	task automatic t_select;
		pol <= 1'b1;
		wr(ON | 32'h80);
		repeat (3) @(negedge pclk);
		chk(slave_selected, 1, "sel low");
		pol <= 1'b0;
		repeat (3) @(negedge pclk);
		chk(slave_selected, 0, "sel high");
		wr(ON);
		chk(slave_selected, 1, "sel unused");
		wr(ON | MST);
		chk(slave_selected, 0, "master");
		wr(ON | MST | AUTO | POL);
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (4) @(negedge pclk);
		chk({select_pin_oe, select_pin_out}, 2'b11, "auto select");
		repeat (8) @(negedge pclk);
	endtask

	task automatic t_frames;
		frm(ON | MST | POL, 1, 0);
		frm(ON | MST | FR | POL, 1, 1);
		frm(ON | MST | FR, 1, 1);
		frm(ON | MST | FR | POL | PW, 1, 8);
		frm(ON | MST | FR | POL | EDG, 1, 1);
		for (int k = 1; k < 6; k++) begin
			frm(ON | MST | FR | POL | (32'(k) << 24), 1 << k, 1);
		end
		frm(ON | FR | DIR | POL, 1, 1);
		frm(ON | FR | DIR, 1, 1);
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, cpu_idle, go, pol} = 6'h0;
		{paddr, pwdata, tx_count, rx_count} = '0;
		{err_count, checks_done} = '0;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_sizes();
		t_modes();
		t_select();
		t_frames();
		conclude();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		$display("mismatch at %0t: timeout", $time);
		conclude();
	end
endmodule
